//--- hw/ccd_decode.sv
// Purpose: decode one instruction word into an operation
// Assumes: word is stable for the current cycle
// Notes: purely combinational
`include "ccd_defs.svh"
module ccd_decode (
  // instruction in
  input wire logic [11:0] instr_i,
  // decoded op out
  output ccd_pkg::ccd_op_t op_o
);
  // priority order is safe: the patterns do not overlap
  always_comb begin
    if (instr_i == `CCD_OP_CLRACC) begin
      op_o = ccd_pkg::CCD_CLRACC;
    end else if (instr_i == `CCD_OP_WDCLR) begin
      op_o = ccd_pkg::CCD_WDCLR;
    end else if ((instr_i & `CCD_MSK_FILE) == `CCD_OP_CLRFILE) begin
      op_o = ccd_pkg::CCD_CLRFILE;
    end else if ((instr_i & `CCD_MSK_FD) == `CCD_OP_CPLFILE) begin
      op_o = ccd_pkg::CCD_CPLFILE;
    end else if ((instr_i & `CCD_MSK_FD) == `CCD_OP_DECFILE) begin
      op_o = ccd_pkg::CCD_DECFILE;
    end else if ((instr_i & `CCD_MSK_FD) == `CCD_OP_DECSKZ) begin
      op_o = ccd_pkg::CCD_DECSKZ;
    end else if ((instr_i & `CCD_MSK_CALL) == `CCD_OP_CALL) begin
      op_o = ccd_pkg::CCD_CALL;
    end else begin
      op_o = ccd_pkg::CCD_NONE;
    end
  end
endmodule

//--- hw/ccd_exec.sv
// Purpose: execute clear, call, watchdog clear, complement, decrement ops
// Assumes: one instruction per clk when instr_valid_i; file read is
//   combinational from file_rdata_i for instr addr bits 4:0
// Notes: all outputs registered; results seen by next instruction
//
// Operation
// - clear accumulator: acc zero, zero flag set
// - call pushes pc plus one in the same cycle as the pc load
// - call loads literal into pc 7:0
// - call clears pc8, page bits fill 10:9
// - call takes two instruction cycles
// - watchdog clear zeroes counter, prescaler if assigned
// - watchdog clear sets timeout and powerdown bits
// - clear file writes zero, sets zero flag
// - complement file to dest, updates zero
// - decrement file to dest, updates zero
// - decrement-skip stores per dest, flags untouched
// - zero result discards prefetch, two cycles
`include "ccd_defs.svh"
module ccd_exec (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // instruction in
  input wire logic instr_valid_i,
  input wire logic [11:0] instr_i,
  input wire logic [10:0] pc_i,
  // operands
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] status_i,
  input wire logic prescaler_to_wdog_i,
  // accumulator and flags
  output logic [7:0] acc_o,
  output logic zero_we_o,
  output logic zero_o,
  // file write
  output ccd_pkg::ccd_fwr_t fwr_o,
  // control flow
  output ccd_pkg::ccd_push_t push_o,
  output logic pc_load_o,
  output logic [10:0] pc_target_o,
  output logic flush_o,
  output logic busy_o,
  // watchdog
  output logic wdog_clear_o,
  output logic presc_clear_o,
  output logic timeout_status_n_o,
  output logic powerdown_status_n_o
);
  ccd_pkg::ccd_op_t op; // decoded op
  logic dest_file; // destination bit
  logic [7:0] alu; // result of complement or decrement
  logic [10:0] ret_addr; // return address
  // registered state
  ccd_pkg::ccd_state_t st_reg, st_next;
  logic [7:0] acc_reg, acc_next;
  logic zwe_reg, zwe_next, z_reg, z_next;
  ccd_pkg::ccd_fwr_t fwr_reg, fwr_next;
  ccd_pkg::ccd_push_t push_reg, push_next;
  logic pcl_reg, pcl_next;
  logic [10:0] pct_reg, pct_next;
  logic flush_reg, flush_next;
  logic wdc_reg, wdc_next, psc_reg, psc_next;
  logic tmo_reg, tmo_next, pwd_reg, pwd_next; // status_n levels
  // shared address arithmetic, used for the push return address only
  function automatic logic [10:0] inc_pc(input logic [10:0] p);
    inc_pc = 11'(p + 11'h001);
  endfunction
  // form call target from literal and page bits
  function automatic logic [10:0] call_tgt(input logic [7:0] k,
                                          input logic [7:0] s);
    call_tgt = {s[`CCD_PAGE_HI:`CCD_PAGE_LO], 1'b0, k};
  endfunction
  ccd_decode u_dec (
    .instr_i(instr_i),
    .op_o(op)
  );

  assign dest_file = instr_i[`CCD_DEST_BIT];
  assign ret_addr = inc_pc(pc_i);
  // complement or decrement, chosen by op
  assign alu = (op == ccd_pkg::CCD_CPLFILE) ? ~file_rdata_i :
               8'(file_rdata_i - 8'h01);

  // next-state computation
  always_comb begin
    st_next = ccd_pkg::CCD_ST_EXEC;
    acc_next = acc_reg;
    zwe_next = 1'b0;
    z_next = z_reg;
    fwr_next = '0;
    push_next = '0;
    pcl_next = 1'b0;
    pct_next = pct_reg;
    flush_next = 1'b0;
    wdc_next = 1'b0;
    psc_next = 1'b0;
    tmo_next = tmo_reg;
    pwd_next = pwd_reg;
    // second cycle of call or skip: nothing executes
    if (st_reg == ccd_pkg::CCD_ST_SECOND) begin
      st_next = ccd_pkg::CCD_ST_EXEC;
    end else if (instr_valid_i) begin
      unique case (op)
        ccd_pkg::CCD_CLRACC: begin
          acc_next = `CCD_ACC_RST;
          zwe_next = 1'b1;
          z_next = 1'b1;
        end
        ccd_pkg::CCD_CLRFILE: begin
          fwr_next = {1'b1, instr_i[4:0], `CCD_ZERO_BYTE};
          zwe_next = 1'b1;
          z_next = 1'b1;
        end
        ccd_pkg::CCD_CPLFILE, ccd_pkg::CCD_DECFILE: begin
          if (dest_file) begin
            fwr_next = {1'b1, instr_i[4:0], alu};
          end else begin
            acc_next = alu;
          end
          zwe_next = 1'b1;
          z_next = (alu == `CCD_ZERO_BYTE);
        end
        ccd_pkg::CCD_DECSKZ: begin
          // no flag write at all
          if (dest_file) begin
            fwr_next = {1'b1, instr_i[4:0], alu};
          end else begin
            acc_next = alu;
          end
          if (alu == `CCD_ZERO_BYTE) begin
            flush_next = 1'b1;
            st_next = ccd_pkg::CCD_ST_SECOND;
          end
        end
        ccd_pkg::CCD_CALL: begin
          push_next = {1'b1, ret_addr};
          pcl_next = 1'b1;
          pct_next = call_tgt(instr_i[7:0], status_i);
          flush_next = 1'b1;
          st_next = ccd_pkg::CCD_ST_SECOND;
        end
        ccd_pkg::CCD_WDCLR: begin
          wdc_next = 1'b1;
          psc_next = prescaler_to_wdog_i;
          tmo_next = 1'b1;
          pwd_next = 1'b1;
        end
        ccd_pkg::CCD_NONE: begin
          st_next = ccd_pkg::CCD_ST_EXEC;
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= ccd_pkg::CCD_ST_EXEC;
      acc_reg <= `CCD_ACC_RST;
      zwe_reg <= 1'b0;
      z_reg <= 1'b0;
      fwr_reg <= '0;
      push_reg <= '0;
      pcl_reg <= 1'b0;
      pct_reg <= `CCD_PC_RST;
      flush_reg <= 1'b0;
      wdc_reg <= 1'b0;
      psc_reg <= 1'b0;
      tmo_reg <= 1'b1;
      pwd_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      acc_reg <= acc_next;
      zwe_reg <= zwe_next;
      z_reg <= z_next;
      fwr_reg <= fwr_next;
      push_reg <= push_next;
      pcl_reg <= pcl_next;
      pct_reg <= pct_next;
      flush_reg <= flush_next;
      wdc_reg <= wdc_next;
      psc_reg <= psc_next;
      tmo_reg <= tmo_next;
      pwd_reg <= pwd_next;
    end
  end

  // outputs straight from flops
  assign acc_o = acc_reg;
  assign zero_we_o = zwe_reg;
  assign zero_o = z_reg;
  assign fwr_o = fwr_reg;
  assign push_o = push_reg;
  assign pc_load_o = pcl_reg;
  assign pc_target_o = pct_reg;
  assign flush_o = flush_reg;
  assign busy_o = st_reg[0]; // only the second state has bit 0 set
  assign wdog_clear_o = wdc_reg;
  assign presc_clear_o = psc_reg;
  assign timeout_status_n_o = tmo_reg;
  assign powerdown_status_n_o = pwd_reg;
  // checks
  logic go; // instruction accepted this cycle
  assign go = instr_valid_i && st_reg == ccd_pkg::CCD_ST_EXEC;

  property p_clracc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CLRACC |=> acc_o == 8'h00 && zero_o && zero_we_o;
  endproperty
  a_clracc: assert property (p_clracc) else $error("clear acc bad");

  property p_push;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CALL |=>
      push_o.push && push_o.addr == 11'($past(pc_i) + 11'h001);
  endproperty
  a_push: assert property (p_push) else $error("call push bad");

  property p_tgt;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CALL |=>
      pc_load_o && pc_target_o[7:0] == $past(instr_i[7:0]);
  endproperty
  a_tgt: assert property (p_tgt) else $error("call low bits bad");

  property p_page;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CALL |=> !pc_target_o[8] &&
      pc_target_o[10:9] == $past(status_i[6:5]);
  endproperty
  a_page: assert property (p_page) else $error("call page bad");

  property p_two;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CALL |=> busy_o ##1 !busy_o;
  endproperty
  a_two: assert property (p_two) else $error("call length bad");

  property p_wdc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_WDCLR |=>
      wdog_clear_o && presc_clear_o == $past(prescaler_to_wdog_i);
  endproperty
  a_wdc: assert property (p_wdc) else $error("wdog clear bad");

  property p_stat;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_WDCLR |=>
      timeout_status_n_o && powerdown_status_n_o;
  endproperty
  a_stat: assert property (p_stat) else $error("status bits bad");

  property p_clear_file_op;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CLRFILE |=> fwr_o.we &&
      fwr_o.data == 8'h00 && fwr_o.addr == $past(instr_i[4:0]) && zero_o;
  endproperty
  a_clear_file_op: assert property (p_clear_file_op) else $error("clear file bad");

  property p_cpl;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_CPLFILE && !dest_file |=>
      acc_o == ~$past(file_rdata_i) && zero_we_o;
  endproperty
  a_cpl: assert property (p_cpl) else $error("complement bad");
  property p_dec;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_DECFILE && dest_file |=> fwr_o.we &&
      fwr_o.data == 8'($past(file_rdata_i) - 8'h01) &&
      zero_o == (fwr_o.data == 8'h00);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement bad");
  property p_dsk_flags;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_DECSKZ |=> !zero_we_o && $stable(zero_o);
  endproperty
  a_dsk_flags: assert property (p_dsk_flags)
    else $error("skip touched flags");
  property p_skip;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && op == ccd_pkg::CCD_DECSKZ |=>
      flush_o == ($past(file_rdata_i) == 8'h01) && busy_o == flush_o;
  endproperty
  a_skip: assert property (p_skip) else $error("skip bad");
  property p_one;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    go && (op == ccd_pkg::CCD_CPLFILE || op == ccd_pkg::CCD_CLRACC)
      |=> !busy_o;
  endproperty
  a_one: assert property (p_one) else $error("single cycle bad");

  c_call: cover property (@(posedge clk_sys_i) go && op == ccd_pkg::CCD_CALL);
  c_skip: cover property (@(posedge clk_sys_i) flush_o && !pc_load_o);
  c_wdc: cover property (@(posedge clk_sys_i) presc_clear_o);
endmodule

//--- include/ccd_defs.svh
// Purpose: constants for the clear/call/decrement execution block
// Assumes: 12-bit instruction words, 32 file registers, 11-bit pc
// Notes: definitions only
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH
// opcode matches (12-bit words)
`define CCD_OP_CLRACC 12'h040
`define CCD_OP_WDCLR 12'h004
`define CCD_MSK_FILE 12'hfe0
`define CCD_OP_CLRFILE 12'h060
`define CCD_MSK_FD 12'hfc0
`define CCD_OP_CPLFILE 12'h240
`define CCD_OP_DECFILE 12'h0c0
`define CCD_OP_DECSKZ 12'h2c0
`define CCD_MSK_CALL 12'hf00
`define CCD_OP_CALL 12'h900
// field positions
`define CCD_DEST_BIT 5
`define CCD_PAGE_LO 5
`define CCD_PAGE_HI 6
// reset values and the zero byte constant
`define CCD_ACC_RST 8'h00
`define CCD_PC_RST 11'h000
`define CCD_ZERO_BYTE 8'h00
`endif

//--- include/ccd_pkg.sv
// Purpose: types for the clear/call/decrement execution block
// Assumes: nothing beyond the defs header
// Notes: ops decoded once per instruction word
package ccd_pkg;
  // decoded operation
  typedef enum logic [2:0] {
    CCD_NONE = 3'h0, CCD_CLRACC = 3'h1, CCD_CLRFILE = 3'h2,
    CCD_CPLFILE = 3'h3, CCD_DECFILE = 3'h4, CCD_DECSKZ = 3'h5,
    CCD_CALL = 3'h6, CCD_WDCLR = 3'h7
  } ccd_op_t;
  // execution phase, gray along fetch/second-cycle path
  typedef enum logic [1:0] {
    CCD_ST_EXEC = 2'b00, CCD_ST_SECOND = 2'b01
  } ccd_state_t;
  // file register write request
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } ccd_fwr_t;
  // stack push request
  typedef struct packed {
    logic push;
    logic [10:0] addr;
  } ccd_push_t;
endpackage

//--- sim/ccd_exec_tb.sv
// Purpose: self-checking bench for the clear/call/decrement exec block
// Assumes: one instruction taken per edge when valid and not busy
// Notes: expectations come from a small model of acc and zero flag
`include "ccd_defs.svh"
module ccd_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs
  logic clk_sys_i, rst_n_i, instr_valid_i, prescaler_to_wdog_i;
  logic [11:0] instr_i;
  logic [10:0] pc_i;
  logic [7:0] file_rdata_i, status_i;
  // design outputs
  logic [7:0] acc_o;
  logic zero_we_o, zero_o, pc_load_o, flush_o, busy_o;
  ccd_pkg::ccd_fwr_t fwr_o;
  ccd_pkg::ccd_push_t push_o;
  logic [10:0] pc_target_o;
  logic wdog_clear_o, presc_clear_o;
  logic timeout_status_n_o, powerdown_status_n_o;
  // bench state
  int errors, checked;
  logic [7:0] exp_acc; // accumulator model
  logic exp_z; // zero flag model

  ccd_exec i_ccd_exec (
    .clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .pc_i,
    .file_rdata_i, .status_i, .prescaler_to_wdog_i,
    .acc_o, .zero_we_o, .zero_o, .fwr_o, .push_o, .pc_load_o,
    .pc_target_o, .flush_o, .busy_o, .wdog_clear_o, .presc_clear_o,
    .timeout_status_n_o, .powerdown_status_n_o
  );

  // free-running 125 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // one comparison, counted
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    checked++;
    if (e !== s) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // issue one op: 0 clr acc,1 clr file,2 complement_file_op,3 decrement_file_op,4 dec skip,
  // 5 call,6 watchdog clear,7 other word; then check the answer cycle
  task automatic run(input logic [2:0] op, input logic [4:0] f,
                     input logic d, input logic [7:0] fd,
                     input logic [7:0] k, input logic [10:0] pc,
                     input logic [7:0] st, input logic ps);
    logic [11:0] w;
    logic [7:0] r;
    logic two, wr, ar;
    case (op)
      3'h0: w = `CCD_OP_CLRACC;
      3'h1: w = `CCD_OP_CLRFILE | {7'h00, f};
      3'h2: w = `CCD_OP_CPLFILE | {6'h00, d, f};
      3'h3: w = `CCD_OP_DECFILE | {6'h00, d, f};
      3'h4: w = `CCD_OP_DECSKZ | {6'h00, d, f};
      3'h5: w = `CCD_OP_CALL | {4'h0, k};
      3'h6: w = `CCD_OP_WDCLR;
      default: w = 12'h000; // outside this group: must do nothing
    endcase
    r = (op == 3'h1) ? 8'h00 : (op == 3'h2) ? ~fd : fd - 8'h01;
    ar = op inside {3'h2, 3'h3, 3'h4};
    wr = (op == 3'h1) || (ar && d);
    two = (op == 3'h5) || (op == 3'h4 && r == 8'h00);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    pc_i <= pc;
    file_rdata_i <= fd;
    status_i <= st;
    prescaler_to_wdog_i <= ps;
    @(posedge clk_sys_i);
    // during a second cycle offer a clear-file that must be ignored
    instr_valid_i <= two;
    instr_i <= `CCD_OP_CLRFILE | 12'h01f;
    #1;
    if (op == 3'h0) exp_acc = 8'h00;
    if (op == 3'h0) exp_z = 1'b1;
    if (ar && !d) exp_acc = r;
    if (op inside {3'h1, 3'h2, 3'h3}) exp_z = (r == 8'h00);
    chk("acc", exp_acc, acc_o);
    chk("zero", exp_z, zero_o);
    chk("zero_we", op < 3'h4, zero_we_o);
    chk("fwr", wr ? {1'b1, f, r} : 14'h0000,
        wr ? fwr_o : {fwr_o.we, 13'h0000});
    chk("push", op == 3'h5 ? {1'b1, pc + 11'h001} : 12'h000,
        op == 3'h5 ? push_o : {push_o.push, 11'h000});
    chk("pc_load", op == 3'h5, pc_load_o);
    if (op == 3'h5)
      chk("target", {st[6:5], 1'b0, k}, pc_target_o);
    chk("flush", two, flush_o);
    chk("busy", two, busy_o);
    chk("wdog", op == 3'h6, wdog_clear_o);
    chk("presc", op == 3'h6 && ps, presc_clear_o);
    chk("status_n", 2'b11,
        {timeout_status_n_o, powerdown_status_n_o});
    if (two) begin
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      #1;
      chk("second", 4'h0,
          {fwr_o.we, busy_o, flush_o, push_o.push});
    end
  endtask

  // main sequence: reset, corner cases, random ops
  initial begin
    errors = 0;
    checked = 0;
    exp_acc = 8'h00;
    exp_z = 1'b0;
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 12'h000;
    pc_i = 11'h000;
    file_rdata_i = 8'h00;
    status_i = 8'h00;
    prescaler_to_wdog_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    chk("rst", 12'h003, {acc_o, busy_o, zero_o,
        timeout_status_n_o, powerdown_status_n_o});
    void'($urandom(32'hc16d)); // fixed seed, set once
    // corner cases: boundaries, wraps and taken skips
    run(3'h0, 5'h00, 1'b0, 8'h00, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h1, 5'h1f, 1'b0, 8'h77, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h2, 5'h00, 1'b0, 8'hff, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h2, 5'h03, 1'b1, 8'h5a, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h3, 5'h04, 1'b0, 8'h00, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h3, 5'h07, 1'b1, 8'h01, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h4, 5'h02, 1'b1, 8'h01, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h4, 5'h02, 1'b0, 8'h01, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h4, 5'h09, 1'b0, 8'h00, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h5, 5'h00, 1'b0, 8'h00, 8'hff, 11'h7ff, 8'h60, 1'b0);
    run(3'h5, 5'h00, 1'b0, 8'h00, 8'h00, 11'h123, 8'h20, 1'b0);
    run(3'h6, 5'h00, 1'b0, 8'h00, 8'h00, 11'h000, 8'h00, 1'b1);
    run(3'h6, 5'h00, 1'b0, 8'h00, 8'h00, 11'h000, 8'h00, 1'b0);
    run(3'h7, 5'h05, 1'b1, 8'h01, 8'h00, 11'h000, 8'h00, 1'b1);
    // random mix, repeatable from the fixed seed
    repeat (400)
      run(3'($urandom), 5'($urandom), 1'($urandom), 8'($urandom),
          8'($urandom), 11'($urandom), 8'($urandom),
          1'($urandom));
    stop_test();
  end
endmodule
